// ===== hw/mmdec_top.v
// Memory map decoder: program, external data and internal data spaces
// Contract
// - Program and external data spaces, 64K each
// - Internal data space of 256 bytes
// - Boot fetches come from 4K boot ROM
// - Boot firmware copies code into code RAM
// - Boot mode: 8K code RAM read/write in xdata
// - ROM-disable bit set enters normal mode
// - Normal mode: boot ROM at 8000h in program
// - Normal mode: code RAM read-only in program
// - Xdata 2K window: buffers, blocks, setup, registers
// - Buffers RAM, registers flip-flops
// - Internal 00h-FFh, special area 80h-FFh
// - Lower 128 bytes direct and indirect
// - Special area direct only
// - External mode decodes A0-A10 only
// - External mode: window aliases every 2K boundary
`include "mmdec_regs.vh"

module mmdec_top #(
    parameter BOOT_AW = 12,
    parameter CODE_AW = 13,
    parameter XWIN_AW = 11
) (
    input  wire        clk,
    input  wire        nrst,
    input  wire        ext_mcu_mode,
    input  wire        prog_req,
    input  wire [15:0] prog_addr,
    output reg  [7:0]  prog_rdata,
    output reg         prog_hit,
    input  wire        boot_rom_data_valid,
    output wire [11:0] boot_rom_addr,
    input  wire [7:0]  boot_rom_rdata,
    input  wire        xdata_req,
    input  wire        xdata_we,
    input  wire [15:0] xdata_addr,
    input  wire [7:0]  xdata_wdata,
    output reg  [7:0]  xdata_rdata,
    output reg         xdata_hit,
    output reg         xdata_wr_refused,
    input  wire        idata_req,
    input  wire        idata_we,
    input  wire        idata_indirect,
    input  wire [7:0]  idata_addr,
    input  wire [7:0]  idata_wdata,
    input  wire [7:0]  sfr_rdata,
    output wire [7:0]  idata_rdata,
    output wire        sfr_sel,
    output wire        sfr_we,
    output wire        idata_refused,
    output wire [6:0]  mmr_index,
    output wire        mmr_we,
    output wire [7:0]  mmr_wdata,
    output wire [7:0]  mmr_rdata_out,
    output wire        normal_mode
);
    localparam ST_BOOT    = 2'b01;
    localparam ST_NORMAL  = 2'b10;
    // Read-data source codes, registered one cycle after the request
    localparam SRC_NONE   = 2'd0;
    localparam SRC_P_CODE = 2'd1;
    localparam SRC_P_BOOT = 2'd2;
    localparam SRC_X_WIN  = 2'd1;
    localparam SRC_X_REG  = 2'd2;
    localparam SRC_X_CODE = 2'd3;

    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [7:0]  mem_cfg;
    reg  [7:0]  mmr [1:`MMDEC_MMR_BYTES-1];
    reg  [7:0]  mmr_rd;
    reg  [1:0]  x_src;
    reg  [1:0]  p_src;
    reg         p_req_d;
    reg         x_req_d;
    wire [7:0]  code_rdata;
    wire [7:0]  win_rdata;

    // Decoder for offsets inside the 2K xdata window; used by both masters
    function [1:0] win_region;
        input [10:0] off;
        begin
            if (off < `MMDEC_EP_CFG_BASE) begin
                win_region = 2'd0;
            end else if (off < `MMDEC_SETUP_BASE) begin
                win_region = 2'd1;
            end else if (off < `MMDEC_MMR_BASE) begin
                win_region = 2'd2;
            end else begin
                win_region = 2'd3;
            end
        end
    endfunction

    // Code RAM occupies the bottom 8K of whichever space it is mapped into
    function in_code_ram;
        input [15:0] a;
        begin
            in_code_ram = a < `MMDEC_CODE_RAM_BYTES;
        end
    endfunction

    // Boot ROM sits at the bottom in boot mode and moves up in normal mode
    function in_boot_rom;
        input        norm;
        input [15:0] a;
        begin
            if (norm) begin
                in_boot_rom = a >= `MMDEC_BOOT_ROM_BASE &&
                              a < `MMDEC_BOOT_ROM_BASE + `MMDEC_BOOT_ROM_BYTES;
            end else begin
                in_boot_rom = a < `MMDEC_BOOT_ROM_BYTES;
            end
        end
    endfunction

    assign normal_mode = state == ST_NORMAL;

    // Window decode: in external mode only A0-A10 matter, so it aliases
    // every 2K; on-chip core sees it only at the top 2K of xdata
    wire [10:0] win_off = xdata_addr[10:0];
    wire        in_win  = ext_mcu_mode ? 1'b1 :
                          ((xdata_addr & ~`MMDEC_XWIN_MASK) == `MMDEC_XWIN_BASE);
    wire [1:0]  region  = win_region(win_off);
    wire        mmr_hit = xdata_req & in_win & (region == 2'd3) &
                          (win_off - `MMDEC_MMR_BASE < `MMDEC_MMR_BYTES);
    wire        ram_hit = xdata_req & in_win & (region != 2'd3);

    // Code RAM is writable in xdata only during boot, never by an external MCU
    wire xcode_hit = xdata_req & ~ext_mcu_mode & ~normal_mode &
                     in_code_ram(xdata_addr);
    wire pcode_hit = prog_req & ~ext_mcu_mode & normal_mode &
                     in_code_ram(prog_addr);
    wire pboot_hit = prog_req & ~ext_mcu_mode &
                     in_boot_rom(normal_mode, prog_addr);

    assign boot_rom_addr = prog_addr[BOOT_AW-1:0];

    wire [CODE_AW-1:0] code_addr = pcode_hit ? prog_addr[CODE_AW-1:0] :
                                               xdata_addr[CODE_AW-1:0];
    wire               code_we   = xcode_hit & xdata_we;

    mmdec_ram #(
        .AW    (CODE_AW),
        .DEPTH (`MMDEC_CODE_RAM_BYTES)
    ) u_code (
        .clk   (clk),
        .we    (code_we),
        .addr  (code_addr),
        .wdata (xdata_wdata),
        .rdata (code_rdata)
    );

    // Buffers, configuration blocks and setup packet share one RAM
    mmdec_ram #(
        .AW    (XWIN_AW),
        .DEPTH (`MMDEC_MMR_BASE)
    ) u_win (
        .clk   (clk),
        .we    (ram_hit & xdata_we),
        .addr  (win_off),
        .wdata (xdata_wdata),
        .rdata (win_rdata)
    );

    mmdec_idata u_idata (
        .clk       (clk),
        .nrst      (nrst),
        .req       (idata_req),
        .we        (idata_we),
        .indirect  (idata_indirect),
        .addr      (idata_addr),
        .wdata     (idata_wdata),
        .sfr_rdata (sfr_rdata),
        .rdata     (idata_rdata),
        .sfr_sel   (sfr_sel),
        .sfr_we    (sfr_we),
        .refused   (idata_refused)
    );

    wire [10:0] mmr_off = win_off - `MMDEC_MMR_BASE;
    assign mmr_index     = mmr_off[6:0];
    assign mmr_we        = mmr_hit & xdata_we;
    assign mmr_wdata     = xdata_wdata;
    assign mmr_rdata_out = mem_cfg;

    // Memory-mapped registers are flip-flops; the first one holds
    // the ROM-disable bit, which the on-chip core or an external MCU may set
    genvar gi;
    generate
        for (gi = 1; gi < `MMDEC_MMR_BYTES; gi = gi + 1) begin : g_mmr
            always @(posedge clk) begin
                if (!nrst) begin
                    mmr[gi] <= 8'h00;
                end else if (mmr_we && mmr_index == gi) begin
                    mmr[gi] <= xdata_wdata;
                end
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (!nrst) begin
            mem_cfg <= `MMDEC_MEMCFG_RESET;
        end else if (mmr_we && mmr_index == 7'h00) begin
            mem_cfg <= xdata_wdata;
        end
    end

    // Offset 0 is the memory configuration register; the rest are plain bytes
    wire [7:0] mmr_word = (mmr_index == 7'h00) ? mem_cfg : mmr[mmr_index];

    always @* begin
        case (state)
            ST_BOOT: begin
                next_state = mem_cfg[`MMDEC_MEMCFG_ROMDIS] ? ST_NORMAL : ST_BOOT;
            end
            ST_NORMAL: begin
                next_state = mem_cfg[`MMDEC_MEMCFG_ROMDIS] ? ST_NORMAL : ST_BOOT;
            end
            default: begin
                next_state = ST_BOOT;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!nrst) begin
            state            <= ST_BOOT;
            mmr_rd           <= 8'h00;
            x_src            <= 2'd0;
            p_src            <= 2'd0;
            p_req_d          <= 1'b0;
            x_req_d          <= 1'b0;
            xdata_wr_refused <= 1'b0;
        end else begin
            state            <= next_state;
            mmr_rd           <= mmr_hit ? mmr_word : 8'h00;
            p_req_d          <= prog_req;
            x_req_d          <= xdata_req;
            p_src            <= pcode_hit ? SRC_P_CODE :
                                (pboot_hit ? SRC_P_BOOT : SRC_NONE);
            x_src            <= ram_hit ? SRC_X_WIN : (mmr_hit ? SRC_X_REG :
                                (xcode_hit ? SRC_X_CODE : SRC_NONE));
            // Program-space code RAM has no write path at all
            xdata_wr_refused <= xdata_req & xdata_we & ~ext_mcu_mode & normal_mode &
                                in_code_ram(xdata_addr);
        end
    end

    always @* begin
        case (p_src)
            SRC_P_CODE: prog_rdata = code_rdata;
            SRC_P_BOOT: prog_rdata = boot_rom_rdata;
            default:    prog_rdata = 8'h00;
        endcase
        prog_hit = p_req_d & (p_src != SRC_NONE) &
                   (p_src != SRC_P_BOOT | boot_rom_data_valid);
        case (x_src)
            SRC_X_WIN:  xdata_rdata = win_rdata;
            SRC_X_REG:  xdata_rdata = mmr_rd;
            SRC_X_CODE: xdata_rdata = code_rdata;
            default:    xdata_rdata = 8'h00;
        endcase
        xdata_hit = x_req_d & (x_src != SRC_NONE);
    end
endmodule

// ===== hw/mmdec_regs.vh
// Address map constants for the memory map decoder
`ifndef MMDEC_REGS_VH
`define MMDEC_REGS_VH
`define MMDEC_BOOT_ROM_BYTES   4096
`define MMDEC_CODE_RAM_BYTES   8192
`define MMDEC_IDATA_BYTES      256
`define MMDEC_EP_BUF_BYTES     1832
`define MMDEC_EP_CFG_BYTES     128
`define MMDEC_SETUP_BYTES      8
`define MMDEC_MMR_BYTES        80
`define MMDEC_BOOT_ROM_BASE    16'h8000
`define MMDEC_CODE_RAM_BASE    16'h0000
`define MMDEC_XWIN_MASK        16'h07FF
`define MMDEC_EP_BUF_BASE      11'h000
`define MMDEC_EP_CFG_BASE      11'h728
`define MMDEC_SETUP_BASE       11'h7A8
`define MMDEC_MMR_BASE         11'h7B0
`define MMDEC_XCODE_BASE       16'h0000
`define MMDEC_XWIN_BASE        16'hF800
`define MMDEC_SFR_BASE         8'h80
`define MMDEC_REG_MEMCFG       11'h7B0
`define MMDEC_MEMCFG_ROMDIS    0
`define MMDEC_MEMCFG_RESET     8'h00
`endif

// ===== hw/mmdec_ram.v
// Single-port synchronous byte RAM with registered read data
module mmdec_ram #(
    parameter AW    = 11,
    parameter DEPTH = 2048
) (
    input  wire          clk,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [7:0]    wdata,
    output reg  [7:0]    rdata
);
    reg [7:0] mem [0:DEPTH-1];

    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// ===== hw/mmdec_idata.v
// Internal data memory: lower 128 bytes RAM, upper 128 bytes special function area
`include "mmdec_regs.vh"
module mmdec_idata (
    input  wire       clk,
    input  wire       nrst,
    input  wire       req,
    input  wire       we,
    input  wire       indirect,
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire [7:0] sfr_rdata,
    output reg  [7:0] rdata,
    output wire       sfr_sel,
    output wire       sfr_we,
    output reg        refused
);
    reg [7:0] lower [0:127];
    wire      upper = addr >= `MMDEC_SFR_BASE;

    // Indirect access never reaches the special function area
    assign sfr_sel = req & upper & ~indirect;
    assign sfr_we  = sfr_sel & we;

    always @(posedge clk) begin
        if (req & ~upper & we) begin
            lower[addr[6:0]] <= wdata;
        end
        if (!nrst) begin
            rdata   <= 8'h00;
            refused <= 1'b0;
        end else begin
            refused <= req & upper & indirect;
            if (req & ~upper) begin
                rdata <= lower[addr[6:0]];
            end else if (sfr_sel) begin
                // Special function data arrives combinationally from its owner
                rdata <= sfr_rdata;
            end else if (req) begin
                rdata <= 8'h00;
            end
        end
    end
endmodule

// ===== bench/mmdec_rom_model.sv
// Boot ROM model answering one cycle after the address
module mmdec_rom_model (
    input  logic        clk,
    input  logic [11:0] addr,
    output logic [7:0]  rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pattern mixes the high address nibble so aliasing shows
    always @(posedge clk) begin
        rdata <= addr[7:0] ^ {addr[11:8], addr[11:8]};
    end
endmodule

// ===== bench/mmdec_top_properties.sv
// Port assertions for the memory map decoder
module mmdec_top_checker (
    input logic        clk,
    input logic        nrst,
    input logic        ext_mcu_mode,
    input logic        prog_req,
    input logic [15:0] prog_addr,
    input logic        prog_hit,
    input logic        xdata_req,
    input logic        xdata_we,
    input logic [15:0] xdata_addr,
    input logic [7:0]  xdata_wdata,
    input logic        xdata_hit,
    input logic        xdata_wr_refused,
    input logic        idata_req,
    input logic        idata_indirect,
    input logic [7:0]  idata_addr,
    input logic        sfr_sel,
    input logic        sfr_we,
    input logic        idata_we,
    input logic        idata_refused,
    input logic [6:0]  mmr_index,
    input logic        mmr_we,
    input logic [7:0]  mmr_wdata,
    input logic        normal_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // External mode sees only A0-A10, so the config register aliases
    sequence s_cfg_set;
        xdata_req && xdata_we && xdata_wdata[0] &&
        (ext_mcu_mode ? xdata_addr[10:0] == 11'h7B0 : xdata_addr == 16'hFFB0);
    endsequence
    sequence s_code_wr;
        xdata_req && xdata_we && !ext_mcu_mode && xdata_addr < 16'h2000;
    endsequence
    a_rom_disable_set: assert property (s_cfg_set |-> ##2 normal_mode)
        else $error("normal mode not entered");
    a_reset_boot: assert property ($rose(nrst) |-> !normal_mode)
        else $error("normal mode after reset");
    a_code_wr_refused: assert property (s_code_wr and normal_mode |=> xdata_wr_refused)
        else $error("code write not refused");
    a_boot_wr_ok: assert property (s_code_wr and !normal_mode |=> !xdata_wr_refused)
        else $error("boot write refused");
    a_ind_upper: assert property (idata_req && idata_indirect && idata_addr[7] |=> idata_refused)
        else $error("indirect upper accepted");
    a_low_ok: assert property (idata_req && !idata_addr[7] |=> !idata_refused)
        else $error("lower access refused");
    a_sfr_direct: assert property (idata_req && !idata_indirect && idata_addr[7] |-> sfr_sel)
        else $error("special area not selected");
    a_boot_fetch: assert property (prog_req && !normal_mode && !ext_mcu_mode
        && prog_addr < 16'h1000 |=> prog_hit)
        else $error("boot fetch missed");
    a_window_hit: assert property (xdata_req && !xdata_we
        && (ext_mcu_mode || xdata_addr[15:11] == 5'h1F) |=> xdata_hit)
        else $error("window read missed");
    a_reg_strobe: assert property (xdata_req && xdata_we && xdata_addr[10:0] >= 11'h7B0
        && (ext_mcu_mode || xdata_addr[15:11] == 5'h1F)
        |-> mmr_we && mmr_index == xdata_addr[6:0] - 7'h30 && mmr_wdata == xdata_wdata)
        else $error("register write strobe missing");
    a_sfr_write: assert property (idata_req && idata_we && !idata_indirect && idata_addr[7]
        |-> sfr_we)
        else $error("special area write strobe missing");
    a_sfr_ind_quiet: assert property (idata_req && idata_indirect |-> !sfr_sel && !sfr_we)
        else $error("special area reached indirectly");
endmodule
bind mmdec_top mmdec_top_checker mmdec_top_checker_inst (.clk(clk), .nrst(nrst),
    .ext_mcu_mode(ext_mcu_mode), .prog_req(prog_req), .prog_addr(prog_addr),
    .prog_hit(prog_hit), .xdata_req(xdata_req), .xdata_we(xdata_we), .xdata_addr(xdata_addr),
    .xdata_wdata(xdata_wdata), .xdata_hit(xdata_hit), .xdata_wr_refused(xdata_wr_refused),
    .idata_req(idata_req), .idata_indirect(idata_indirect), .idata_addr(idata_addr),
    .sfr_sel(sfr_sel), .sfr_we(sfr_we), .idata_we(idata_we), .idata_refused(idata_refused),
    .mmr_index(mmr_index), .mmr_we(mmr_we), .mmr_wdata(mmr_wdata),
    .normal_mode(normal_mode));

// ===== bench/mmdec_top_tb.sv
// Self-checking bench for the memory map decoder
module mmdec_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, nrst = 0, ext_mcu_mode = 0, prog_req = 0;
    logic        xdata_req = 0, xdata_we = 0, idata_req = 0, idata_we = 0, idata_indirect = 0;
    logic [15:0] prog_addr = 16'h0000, xdata_addr = 16'h0000;
    logic [7:0]  xdata_wdata = 8'h00, idata_addr = 8'h00, idata_wdata = 8'h00;
    logic [7:0]  prog_rdata, xdata_rdata, idata_rdata, boot_rom_rdata, mmr_rdata_out;
    logic [11:0] boot_rom_addr;
    logic        prog_hit, xdata_hit, xdata_wr_refused, idata_refused, normal_mode, sfr_sel;
    int          miscompares = 0, tests_run = 0, cycles = 0;
    mmdec_top mmdec_top_inst (.clk(clk), .nrst(nrst), .ext_mcu_mode(ext_mcu_mode),
        .prog_req(prog_req), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
        .prog_hit(prog_hit), .boot_rom_data_valid(1'b1), .boot_rom_addr(boot_rom_addr),
        .boot_rom_rdata(boot_rom_rdata), .xdata_req(xdata_req), .xdata_we(xdata_we),
        .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata), .xdata_rdata(xdata_rdata),
        .xdata_hit(xdata_hit), .xdata_wr_refused(xdata_wr_refused), .idata_req(idata_req),
        .idata_we(idata_we), .idata_indirect(idata_indirect), .idata_addr(idata_addr),
        .idata_wdata(idata_wdata), .sfr_rdata(8'hA5), .idata_rdata(idata_rdata),
        .sfr_sel(sfr_sel), .sfr_we(), .idata_refused(idata_refused), .mmr_index(),
        .mmr_we(), .mmr_wdata(), .mmr_rdata_out(mmr_rdata_out), .normal_mode(normal_mode));
    mmdec_rom_model mmdec_rom_model_inst (.clk(clk), .addr(boot_rom_addr),
        .rdata(boot_rom_rdata));
    always #50 clk = ~clk;
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] rom(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], a[11:8]};
    endfunction
    task automatic xacc(input logic we, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        xdata_req <= 1'b1;
        xdata_we <= we;
        xdata_addr <= a;
        xdata_wdata <= d;
        @(posedge clk);
        xdata_req <= 1'b0;
        #1;
    endtask
    task automatic pacc(input logic [15:0] a);
        @(posedge clk);
        prog_req <= 1'b1;
        prog_addr <= a;
        @(posedge clk);
        prog_req <= 1'b0;
        #1;
    endtask
    task automatic iacc(input logic we, input logic ind, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        idata_req <= 1'b1;
        idata_we <= we;
        idata_indirect <= ind;
        idata_addr <= a;
        idata_wdata <= d;
        @(posedge clk);
        idata_req <= 1'b0;
        #1;
    endtask
    task automatic t_boot;
        chk("normal_mode", 0, normal_mode);
        chk("mem_cfg", 8'h00, mmr_rdata_out);
        xacc(1, 16'h1FFF, 8'h5A);
        chk("boot_refused", 0, xdata_wr_refused);
        xacc(0, 16'h1FFF, 8'h00);
        chk("code_ram", 8'h5A, xdata_rdata);
        pacc(16'h0ABC);
        chk("rom_fetch", rom(12'hABC), prog_rdata);
        xacc(1, 16'hF8FF, 8'hC3);
        xacc(0, 16'hF8FF, 8'h00);
        chk("ep_buf", 8'hC3, xdata_rdata);
        xacc(1, 16'hFFB5, 8'h77);
        xacc(0, 16'hFFB5, 8'h00);
        chk("mmr_reg", 8'h77, xdata_rdata);
        xacc(0, 16'h4000, 8'h00);
        chk("unmapped_hit", 0, xdata_hit);
    endtask
    task automatic t_normal;
        xacc(1, 16'hFFB0, 8'h01);
        @(posedge clk);
        #1;
        chk("normal_mode", 1, normal_mode);
        chk("mem_cfg", 8'h01, mmr_rdata_out);
        xacc(0, 16'hFFB0, 8'h00);
        chk("cfg_read", 8'h01, xdata_rdata);
        pacc(16'h1FFF);
        chk("code_fetch", 8'h5A, prog_rdata);
        chk("code_hit", 1, prog_hit);
        xacc(1, 16'h1FFF, 8'h00);
        chk("wr_refused", 1, xdata_wr_refused);
        pacc(16'h1FFF);
        chk("code_kept", 8'h5A, prog_rdata);
        pacc(16'h8123);
        chk("rom_high", rom(12'h123), prog_rdata);
        pacc(16'h4000);
        chk("fetch_miss", 0, prog_hit);
    endtask
    task automatic t_reset;
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        chk("reset_mode", 0, normal_mode);
        chk("reset_cfg", 8'h00, mmr_rdata_out);
        pacc(16'h0ABC);
        chk("boot_again", rom(12'hABC), prog_rdata);
    endtask
    task automatic t_idata;
        iacc(1, 0, 8'h7F, 8'h96);
        iacc(0, 1, 8'h7F, 8'h00);
        chk("idata_ind", 8'h96, idata_rdata);
        iacc(1, 1, 8'h80, 8'h11);
        chk("upper_refused", 1, idata_refused);
        chk("upper_ind_data", 8'h00, idata_rdata);
        iacc(0, 0, 8'h80, 8'h00);
        chk("upper_direct", 0, idata_refused);
        chk("sfr_read", 8'hA5, idata_rdata);
        iacc(1, 0, 8'h81, 8'h22);
        chk("sfr_write", 0, idata_refused);
    endtask
    task automatic t_ext;
        @(posedge clk);
        ext_mcu_mode <= 1'b1;
        xacc(1, 16'h37B0, 8'h01);
        @(posedge clk);
        #1;
        chk("alias_cfg", 1, normal_mode);
        xacc(0, 16'hC7B0, 8'h00);
        chk("alias_read", 8'h01, xdata_rdata);
        xacc(1, 16'h0805, 8'h3E);
        xacc(0, 16'hF805, 8'h00);
        chk("alias_buf", 8'h3E, xdata_rdata);
        chk("alias_hit", 1, xdata_hit);
    endtask
    task automatic end_sim;
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Whole run needs about sixty-five cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            end_sim;
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        t_boot;
        t_normal;
        t_reset;
        t_idata;
        t_ext;
        end_sim;
    end
endmodule
